// ==== verilog/sec_pkg.sv ====
// constants and types shared by the serial eeprom command logic.
// assumes a single system clock at the rate given below; the link
// clock comes from the spi master and is handled in the core.
package sec_pkg;

    ////////////////////////////////////////////////////////////////////////
    // instruction opcodes, eight bits, msb first on the wire
    localparam logic [7:0] OP_SET_WL   = 8'h06; // set_write_latch_cmd
    localparam logic [7:0] OP_CLR_WL   = 8'h04; // clear_write_latch_cmd
    localparam logic [7:0] OP_STAT_RD  = 8'h05; // status_read_cmd
    localparam logic [7:0] OP_STAT_WR  = 8'h01; // status_write_cmd
    localparam logic [7:0] OP_ARR_RD   = 8'h03; // array read
    localparam logic [7:0] OP_ARR_WR   = 8'h02; // array write

    ////////////////////////////////////////////////////////////////////////
    // status byte field positions
    localparam int ST_BUSY     = 0;  // programming in progress
    localparam int ST_WEL      = 1;  // write latch
    localparam int ST_LEVEL_LO = 2;  // protect_level_lo
    localparam int ST_LEVEL_HI = 3;  // protect_level_hi

    // protect levels and the first protected address of each
    localparam logic [1:0] LVL_NONE    = 2'b00;
    localparam logic [1:0] LVL_QUARTER = 2'b01;
    localparam logic [1:0] LVL_HALF    = 2'b10;
    localparam logic [1:0] LVL_ALL     = 2'b11;
    localparam logic [7:0] QUARTER_BASE = 8'hc0;
    localparam logic [7:0] HALF_BASE    = 8'h80;

    // values after reset
    localparam logic [1:0] LEVEL_RST = 2'b00; // nothing protected
    localparam logic       WEL_RST   = 1'b0;  // write disabled
    localparam logic       CLR_RST   = 1'b1;  // link logic held clear

    ////////////////////////////////////////////////////////////////////////
    // frame byte counter values (saturates on the data byte)
    localparam logic [1:0] BYTE_OP   = 2'h0;
    localparam logic [1:0] BYTE_ADDR = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;

    localparam int PAGE_BYTES = 4;   // page write buffer depth
    localparam int ADDR_W     = 8;   // byte address width

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ        = 25;        // clk_sys rate
    localparam int T_PROG_NS_DEF  = 5_000_000; // self-timed write, ns

    // what the finished programming cycle has to commit
    typedef enum logic [1:0] {
        PEND_NONE,
        PEND_ARRAY,
        PEND_STATUS
    } sec_pend_t;

    // address falls inside the block chosen by the protect level
    function automatic logic sec_prot_hit(input logic [1:0] lvl,
                                          input logic [7:0] addr);
        unique case (lvl)
            LVL_NONE:    sec_prot_hit = 1'b0;
            LVL_QUARTER: sec_prot_hit = (addr >= QUARTER_BASE);
            LVL_HALF:    sec_prot_hit = (addr >= HALF_BASE);
            LVL_ALL:     sec_prot_hit = 1'b1;
        endcase
    endfunction

    // opcode is one of the six the device knows
    function automatic logic sec_op_known(input logic [7:0] op);
        sec_op_known = (op == OP_SET_WL) || (op == OP_CLR_WL) ||
                       (op == OP_STAT_RD) || (op == OP_STAT_WR) ||
                       (op == OP_ARR_RD) || (op == OP_ARR_WR);
    endfunction

endpackage

// ==== verilog/sec_core.sv ====
// serial eeprom command logic: spi slave front end on the link clock,
// array, status and self-timed programming on clk_sys.
// assumes spi mode 0 from the master, select held high a few clk_sys
// cycles between frames, and si driven from the master's sck domain.
//
// Operation
// - read opcode, address, then data streams out
// - read address increments and wraps around
// - status bits 3 and 2 carry protect level
// - status bit 1 shows the write latch
// - status bit 0 shows programming busy
// - during busy only busy bit is meaningful
// - status read shifts eight bits msb first
// - latch clear at start; set before writes
// - clear-latch command blocks later writes
// - array write needs wp, latch, unprotected address
// - level selects none, c0-ff, 80-ff, all
// - programming starts on select rise after frame
// - only status read accepted while busy
// - page write wraps low two address bits
// - finished write clears the write latch
// - write without latch is dropped silently
// - status write changes only the level bits
// - status write needs wp high and latch
// - status programs on select rise at boundary
// - unknown opcode ignored until next select
// - opcode values for the four fixed commands
// - all fields travel msb first
// - sample on rising, drive after falling edge
// - wp low never aborts a started write
module sec_core #(
    parameter int T_PROG_NS = sec_pkg::T_PROG_NS_DEF // write cycle, ns
) (
    input  wire logic clk_sys,  // system clock
    input  wire logic resetn,   // synchronous reset, active low
    input  wire logic ce,       // clock enable for the clk_sys domain
    input  wire logic sck_clk,  // spi serial clock from the master
    input  wire logic cs_n,     // select, active low
    input  wire logic si,       // serial data in
    input  wire logic wp_n,     // write protect, active low
    output logic      so_out,   // serial data out
    output logic      so_oe_n   // serial out enable, low while driving
);
    import sec_pkg::*;

    // programming time in clk_sys cycles, rounded up
    localparam int PROG_CYC = (T_PROG_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W    = $clog2(PROG_CYC + 1);
    localparam logic [TMR_W-1:0] PROG_LAST = TMR_W'(PROG_CYC - 1);

    generate
        if (PROG_CYC < 1) begin : g_bad_time
            $error("sec_core: programming time below one cycle");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // storage and system-domain state
    logic [7:0]       mem [0:(1<<ADDR_W)-1]; // the array itself
    logic             cs_m_reg, cs_s_reg;    // select synchroniser
    logic             cs_d_reg;              // select one cycle later
    logic             wp_m_reg, wp_s_reg;    // write protect synchroniser
    logic             clr_reg;               // holds link logic clear
    logic             busy_reg;              // programming running
    logic             wel_reg;               // write latch
    logic [1:0]       lvl_reg;               // protect level
    logic [TMR_W-1:0] tmr_reg;               // programming timer
    sec_pend_t        pend_reg;              // what to commit
    logic [5:0]       pend_base_reg;         // page address, high bits
    logic [3:0]       pend_ld_reg;           // page bytes loaded
    logic [7:0]       pend_data_reg [0:PAGE_BYTES-1];
    logic [1:0]       pend_lvl_reg;          // new protect level

    ////////////////////////////////////////////////////////////////////////
    // link-domain state (sck_clk)
    logic [7:0]       sh_reg;                // input shifter
    logic [2:0]       bit_idx_reg;           // bit within byte
    logic [1:0]       byte_cnt_reg;          // bytes seen, saturating
    logic [7:0]       op_reg;                // latched opcode
    logic [7:0]       addr_reg;              // address or status data
    logic [7:0]       rd_addr_reg;           // streaming read address
    logic [2:0]       out_idx_reg;           // output bit, 0 is msb
    logic             dead_reg;              // frame refused
    logic             rd_act_reg;            // array data streaming
    logic             st_act_reg;            // status streaming
    logic [1:0]       pg_ptr_reg;            // page slot for next byte
    logic [3:0]       pg_ld_reg;             // page slots written
    logic [7:0]       pg_data_reg [0:PAGE_BYTES-1];
    logic [3:0]       stat_m_reg, stat_s_reg; // status synchroniser

    ////////////////////////////////////////////////////////////////////////
    // link-side decoding
    wire logic [7:0] rx_byte   = {sh_reg[6:0], si};
    wire logic       shifting  = !dead_reg && !rd_act_reg && !st_act_reg;
    wire logic       byte_done = shifting && (bit_idx_reg == 3'h7);
    wire logic       st_busy_l = stat_s_reg[ST_BUSY];
    // unknown codes and anything but status read while busy are refused
    wire logic       op_refuse = !sec_op_known(rx_byte) ||
                       (st_busy_l && (rx_byte != OP_STAT_RD));
    wire logic       op_done   = byte_done && (byte_cnt_reg == BYTE_OP);
    wire logic       addr_done = byte_done && (byte_cnt_reg == BYTE_ADDR);
    wire logic       data_done = byte_done && (byte_cnt_reg == BYTE_DATA);
    wire logic       page_load = data_done && (op_reg == OP_ARR_WR);
    wire logic [7:0] rd_byte   = mem[rd_addr_reg];
    wire logic [7:0] stat_byte = {4'h0, stat_s_reg};
    wire logic [2:0] out_sel   = ~out_idx_reg;
    wire logic       tx_bit    = rd_act_reg ? rd_byte[out_sel]
                                            : stat_byte[out_sel];
    wire logic [3:0] stat_live = {lvl_reg, wel_reg, busy_reg};

    ////////////////////////////////////////////////////////////////////////
    // link control: cleared by the system side between frames, so a
    // new frame always starts at bit 0 even though sck is not free
    always_ff @(posedge sck_clk or posedge clr_reg) begin
        if (clr_reg) begin
            bit_idx_reg  <= 3'h0;
            byte_cnt_reg <= BYTE_OP;
            dead_reg     <= 1'b0;
            rd_act_reg   <= 1'b0;
            st_act_reg   <= 1'b0;
            out_idx_reg  <= 3'h0;
            pg_ld_reg    <= 4'h0;
        end else begin
            // bit counter runs only while input is being taken
            if (shifting) begin
                bit_idx_reg <= bit_idx_reg + 3'h1;
            end
            if (byte_done && (byte_cnt_reg != BYTE_DATA)) begin
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
            end
            // opcode complete: refuse, or start a status stream
            if (op_done) begin
                dead_reg   <= op_refuse;
                st_act_reg <= !op_refuse && (rx_byte == OP_STAT_RD);
            end
            // address complete on a read: data follows, si ignored
            if (addr_done && (op_reg == OP_ARR_RD)) begin
                rd_act_reg <= 1'b1;
            end
            if (page_load) begin
                pg_ld_reg[pg_ptr_reg] <= 1'b1;
            end
            // one output bit consumed per rising edge
            if (rd_act_reg || st_act_reg) begin
                out_idx_reg <= out_idx_reg + 3'h1;
            end
        end
    end

    // link data path, no reset needed: qualified by the control above
    always_ff @(posedge sck_clk) begin
        sh_reg <= rx_byte;
        if (op_done) begin
            op_reg <= rx_byte;
        end
        if (addr_done) begin
            addr_reg   <= rx_byte;
            rd_addr_reg <= rx_byte;
            pg_ptr_reg <= rx_byte[1:0];
        end else if (rd_act_reg && (out_idx_reg == 3'h7)) begin
            rd_addr_reg <= rd_addr_reg + 8'h01;
        end
        // page slot advances in the low two bits only, overwriting
        if (page_load) begin
            pg_data_reg[pg_ptr_reg] <= rx_byte;
            pg_ptr_reg              <= pg_ptr_reg + 2'h1;
        end
    end

    // status into the link domain; settles during the opcode byte.
    // the four bits are independent flags that change at most once per
    // frame, so no gray code is needed: a bit caught mid
    // change reads old or new, both legal for a status poll.
    // limitation: a change shows only after two sck rises in a frame,
    // so the opcode byte itself always carries the synchronising edges.
    always_ff @(posedge sck_clk) begin
        stat_m_reg <= stat_live;
        stat_s_reg <= stat_m_reg;
    end

    // serial out changes after falling edges; the link clear releases it at once
    always_ff @(negedge sck_clk or posedge clr_reg) begin
        if (clr_reg) begin
            so_out  <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so_oe_n <= !(rd_act_reg || st_act_reg);
            so_out  <= tx_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame end decoding; link registers are still since sck stopped
    wire logic fr_end  = cs_s_reg && !cs_d_reg;
    wire logic fr_full = !dead_reg && (bit_idx_reg == 3'h0);
    wire logic fr_cmd  = fr_end && fr_full && !busy_reg &&
                         (byte_cnt_reg != BYTE_OP);
    wire logic fr_data = fr_cmd && (byte_cnt_reg == BYTE_DATA);
    wire logic wr_ok   = wel_reg && wp_s_reg;
    wire logic pg_prot = sec_prot_hit(lvl_reg, addr_reg);
    wire logic fr_wr   = fr_data && (op_reg == OP_ARR_WR) && wr_ok &&
                         !pg_prot && (pg_ld_reg != 4'h0);
    wire logic fr_sw   = fr_data && (op_reg == OP_STAT_WR) && wr_ok;
    wire logic fr_set  = fr_cmd && (op_reg == OP_SET_WL);
    wire logic fr_clrw = fr_cmd && (op_reg == OP_CLR_WL);
    wire logic prog_done = busy_reg && (tmr_reg == PROG_LAST);

    // pin synchronisers and select edge
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            cs_d_reg <= 1'b1;
            wp_m_reg <= 1'b0;
            wp_s_reg <= 1'b0;
            clr_reg  <= CLR_RST;
        end else if (ce) begin
            cs_m_reg <= cs_n;
            cs_s_reg <= cs_m_reg;
            cs_d_reg <= cs_s_reg;
            wp_m_reg <= wp_n;
            wp_s_reg <= wp_m_reg;
            // one-cycle clear after the frame has been taken over
            clr_reg  <= fr_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write latch, busy, protect level and programming timer.
    // wp is checked only when programming starts, never during it.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
            wel_reg  <= WEL_RST;
            lvl_reg  <= LEVEL_RST;
            tmr_reg  <= '0;
            pend_reg <= PEND_NONE;
        end else if (ce) begin
            if (fr_wr || fr_sw) begin
                busy_reg <= 1'b1;
                tmr_reg  <= '0;
                pend_reg <= fr_wr ? PEND_ARRAY : PEND_STATUS;
            end else if (prog_done) begin
                busy_reg <= 1'b0;
                wel_reg  <= 1'b0;
                pend_reg <= PEND_NONE;
                if (pend_reg == PEND_STATUS) begin
                    lvl_reg <= pend_lvl_reg;
                end
            end else if (busy_reg) begin
                tmr_reg <= tmr_reg + TMR_W'(1);
            end
            if (fr_set) begin
                wel_reg <= 1'b1;
            end
            if (fr_clrw) begin
                wel_reg <= 1'b0;
            end
        end
    end

    // copy the frame into pending registers as programming starts
    always_ff @(posedge clk_sys) begin
        if (ce && (fr_wr || fr_sw)) begin
            pend_base_reg <= addr_reg[7:2];
            pend_ld_reg   <= pg_ld_reg;
            pend_lvl_reg  <= addr_reg[ST_LEVEL_HI:ST_LEVEL_LO];
            for (int i = 0; i < PAGE_BYTES; i++) begin
                pend_data_reg[i] <= pg_data_reg[i];
            end
        end
    end

    // array commit at the end of the cycle; reads are refused while
    // busy, so the link side never sees the array change mid-byte
    always_ff @(posedge clk_sys) begin
        if (ce && prog_done && (pend_reg == PEND_ARRAY)) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pend_ld_reg[i]) begin
                    mem[{pend_base_reg, 2'(i)}] <= pend_data_reg[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    wp_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && fr_end && !wp_s_reg && !busy_reg) |=> !busy_reg)
        else $error("write started with protect pin low");

    latch_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && fr_end && !wel_reg && !busy_reg) |=> !busy_reg)
        else $error("write started without write latch");

    all_prot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && fr_end && (lvl_reg == LVL_ALL) && (op_reg == OP_ARR_WR)
         && !busy_reg) |=> !busy_reg)
        else $error("array write started in fully protected state");

    done_clears_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(busy_reg) |-> !wel_reg && $past(tmr_reg) == PROG_LAST)
        else $error("programming end did not clear latch or ran short");

    level_only_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $changed(lvl_reg) |-> $fell(busy_reg) && $past(pend_reg) == PEND_STATUS)
        else $error("protect level changed outside status write end");

    latch_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && fr_end && fr_full && !busy_reg && op_reg == OP_SET_WL &&
         byte_cnt_reg != BYTE_OP) |=> wel_reg)
        else $error("set latch command did not set latch");

    latch_clr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && fr_end && fr_full && !busy_reg && op_reg == OP_CLR_WL &&
         byte_cnt_reg != BYTE_OP) |=> !wel_reg ##1 !busy_reg[*2])
        else $error("clear latch command did not take effect");

    busy_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (busy_reg && !prog_done) |=> busy_reg)
        else $error("programming cycle cut short");

    dead_quiet_a: assert property (@(posedge sck_clk) disable iff (clr_reg)
        dead_reg |-> so_oe_n && !rd_act_reg && !st_act_reg)
        else $error("refused frame drives serial out");

    // so stays released while opcode, address or data come in
    input_quiet_a: assert property (@(posedge sck_clk) disable iff (clr_reg)
        shifting |-> so_oe_n)
        else $error("serial out driven while taking input");

    // status stream drives the line from the falling edge after bit 8
    status_drive_a: assert property (@(posedge sck_clk) disable iff (clr_reg)
        st_act_reg |-> !so_oe_n)
        else $error("status stream not driving serial out");

    // array stream drives the line from the falling edge after bit 16
    read_drive_a: assert property (@(posedge sck_clk) disable iff (clr_reg)
        rd_act_reg |-> !so_oe_n)
        else $error("array stream not driving serial out");

    // programming only ever starts from a select rise
    start_frame_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(busy_reg) |-> $past(fr_end))
        else $error("programming started without a frame end");

    // the link clear is a single pulse, so the next frame is never held
    clr_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && clr_reg) |=> !clr_reg)
        else $error("link clear held longer than one cycle");

endmodule // sec_core

// ==== tb/sec_spi_master.sv ====
// spi mode 0 master model driving the eeprom link pins.
// assumes the bench resolves so and calls xfer one frame at a time.
module sec_spi_master (
    output logic sck_clk,  // link clock, still outside frames
    output logic cs_n,     // select, active low
    output logic si,       // serial data to the device
    input  wire  so_w,     // resolved serial data from the device
    input  wire  so_oe_n   // device output enable, low while driving
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sck_clk = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one frame: ntx bytes out, then nrx bytes in; 48 ns link period
    task automatic xfer(input logic [63:0] tx, input int ntx,
                        input int nrx, output logic [31:0] rx,
                        output logic drove);
        int i;
        rx    = 32'h0;
        drove = 1'b0;
        cs_n <= 1'b0;
        #24;
        for (i = 8 * ntx - 1; i >= 0; i--) begin
            si <= tx[i];
            #24 sck_clk <= 1'b1;
            #24 sck_clk <= 1'b0;
        end
        for (i = 0; i < 8 * nrx; i++) begin
            si <= ~si; // input is junk while reading
            #24;
            rx = {rx[30:0], so_w}; // sampled just before the rise
            if (so_oe_n === 1'b0) drove = 1'b1;
            sck_clk <= 1'b1;
            #24 sck_clk <= 1'b0;
        end
        #24 cs_n <= 1'b1;
    endtask
endmodule // sec_spi_master

// ==== tb/spi_eeprom_command_logic_tb.sv ====
// self-checking bench: a table of spi frames, then a mid-run reset.
// assumes sec_core with a short write cycle and the master model.
module spi_eeprom_command_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sec_pkg::*;

    typedef struct {
        logic [63:0] tx; int ntx; int nrx;
        logic [31:0] ex; logic [31:0] mk; logic wp; int gap;
    } sec_row_t;

    logic        clk_sys, resetn, ce, wp_n;  // system side inputs
    logic        sck_clk, cs_n, si;          // link pins from master
    logic        so_out, so_oe_n, so_hz;     // device output, idle junk
    wire         so_w = so_oe_n ? so_hz : so_out; // released line flips
    logic [31:0] rx;
    logic        dr;
    int          err_count, total_checks;

    ////////////////////////////////////////////////////////////////////////
    // zero mask with reads means the device must stay silent
    sec_row_t rows [36] = '{
        '{64'h05, 1, 1, 32'h00, 32'hff, 1'b1, 400},
        '{64'h021055, 3, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h05, 1, 1, 32'h00, 32'hff, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h05, 1, 1, 32'h02, 32'hff, 1'b1, 400},
        '{64'h04, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h05, 1, 1, 32'h00, 32'hff, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h0210a1b2c3d4e5, 7, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h0310, 2, 1, 32'h0, 32'h0, 1'b1, 400},
        '{64'h05, 1, 1, 32'h01, 32'h01, 1'b1, 4000},
        '{64'h0310, 2, 4, 32'he5b2c3d4, '1, 1'b1, 400},
        '{64'h05, 1, 1, 32'h00, 32'hff, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h02fc11223377, 6, 0, 32'h0, 32'h0, 1'b1, 4000},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h020088, 3, 0, 32'h0, 32'h0, 1'b1, 4000},
        '{64'h03ff, 2, 2, 32'h7788, 32'hffff, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h01ff, 2, 0, 32'h0, 32'h0, 1'b1, 4000},
        '{64'h05, 1, 1, 32'h0c, 32'hff, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h021000, 3, 0, 32'h0, 32'h0, 1'b1, 4000},
        '{64'h0310, 2, 1, 32'he5, 32'hff, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b0, 400},
        '{64'h0100, 2, 0, 32'h0, 32'h0, 1'b0, 4000},
        '{64'h05, 1, 1, 32'h0c, 32'h0d, 1'b0, 400},
        '{64'ha5, 1, 1, 32'h0, 32'h0, 1'b1, 400},
        '{64'h05, 1, 1, 32'h0c, 32'h0d, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h0104, 2, 0, 32'h0, 32'h0, 1'b1, 4000},
        '{64'h05, 1, 1, 32'h04, 32'hff, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400},
        '{64'h02fc55, 3, 0, 32'h0, 32'h0, 1'b1, 4000},
        '{64'h03fc, 2, 1, 32'h11, 32'hff, 1'b1, 400},
        '{64'h06, 1, 0, 32'h0, 32'h0, 1'b1, 400}
    };

    sec_core #(.T_PROG_NS(4000)) DUT (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .sck_clk(sck_clk), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .so_out(so_out), .so_oe_n(so_oe_n)
    );

    sec_spi_master m (
        .sck_clk(sck_clk), .cs_n(cs_n), .si(si),
        .so_w(so_w), .so_oe_n(so_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // 25 mhz system clock; released so line changes every link cycle
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;
    initial so_hz = 1'b0;
    always @(negedge sck_clk) so_hz <= (so_w === 1'b1) ? 1'b0 : 1'b1;

    task automatic chk(input logic ok, input int k);
        total_checks++;
        if (ok !== 1'b1) begin
            $display("mismatch %0t step %0d got %h", $time, k, rx);
            err_count++;
        end
    endtask

    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // watchdog: a hung run ends as a failure
    initial begin
        #2_000_000;
        chk(1'b0, -1);
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, table walk, reset in mid-run
    initial begin
        resetn = 1'b0;
        ce     = 1'b1;
        wp_n   = 1'b1;
        err_count    = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        foreach (rows[k]) begin
            @(posedge clk_sys) wp_n <= rows[k].wp;
            #1 m.xfer(rows[k].tx, rows[k].ntx, rows[k].nrx, rx, dr);
            #(rows[k].gap);
            if (rows[k].nrx > 0)
                chk(((rx & rows[k].mk) === (rows[k].ex & rows[k].mk)) &&
                    (dr === (rows[k].mk != 32'h0)), k);
        end
        // latch was set last; a reset must bring status back to zero
        @(posedge clk_sys) resetn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 m.xfer(64'h05, 1, 1, rx, dr);
        chk((rx[7:0] === 8'h00) && (dr === 1'b1), 99);
        // clock enable low must freeze the programming timer
        #400 m.xfer(64'h06, 1, 0, rx, dr);
        #400 m.xfer(64'h0100, 2, 0, rx, dr);
        #400 @(posedge clk_sys) ce <= 1'b0;
        #5000 @(posedge clk_sys) ce <= 1'b1;
        #1 m.xfer(64'h05, 1, 1, rx, dr);
        chk((rx[0] === 1'b1) && (dr === 1'b1), 100);
        #5000 m.xfer(64'h05, 1, 1, rx, dr);
        chk((rx[7:0] === 8'h00) && (dr === 1'b1), 101);
        print_verdict();
    end
endmodule // spi_eeprom_command_logic_tb
